// [hw/txu_unpacker.sv]
/*
  Transmit buffer command unpacker: parses command words, strips
  offset and alignment filler, forwards payload bytes to the MAC.
  Assumes dwords arrive in buffer order and one clock domain.
*/
`timescale 1ns/10ps
module txu_unpacker
  import txu_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic [31:0] inDword, // dword from tx data fifo
  input wire logic inValid, // dword present
  output logic inReady, // dword taken when valid
  output logic [7:0] macByte, // payload byte
  output logic macValid, // byte present
  input wire logic macReady, // mac accepts byte
  output logic macLast, // last byte of packet
  output logic macCrcOff, // no check sequence
  output logic macPadOff, // no short frame padding
  output logic transmitErrorFlag, // length mismatch, sticky
  input wire logic errClear, // clears error flag
  output logic bufferLoadedFlag, // buffer loaded, sticky
  input wire logic doneClear, // clears loaded flag
  output logic statusValid, // status pulse per packet
  output logic [15:0] statusTag, // tag of that packet
  output logic statusLenErr // length mismatch of packet
);
  typedef struct packed {
    txu_state_type st;
    logic rdy;
    logic [SIZE_W-1:0] size;
    logic [1:0] lane;
    logic [2:0] skip;
    logic [1:0] align;
    logic [9:0] dw;
    logic [2:0] pad;
    logic [31:0] word;
    logic [1:0] idx;
    logic [SIZE_W-1:0] left;
    logic [SIZE_W-1:0] sum;
    logic [SIZE_W-1:0] len;
    logic [TAG_W-1:0] tag;
    logic crcOff;
    logic padOff;
    logic first;
    logic fs;
    logic ls;
    logic irq;
    logic err;
    logic done;
    logic stV;
    logic stErr;
    logic [TAG_W-1:0] stTag;
  } txu_unp_type;

  txu_unp_type r_q, r_d;
  logic take;
  logic push;
  logic [SIZE_W-1:0] sumNext;

  txu_stream_if #(.W(BUF_W)) upIf ();
  txu_stream_if #(.W(BUF_W)) dnIf ();

  // two entries ride out one cycle of mac stall without a bubble
  txu_skid_buf #(.W(BUF_W)) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .upI(upIf.snk),
    .dnI(dnIf.src)
  );

  // mac side straight from the buffer's output flops
  assign dnIf.ready = macReady;
  assign macByte = dnIf.data[7:0];
  assign macValid = dnIf.valid;
  assign macLast = dnIf.data[BW_LAST];
  assign macCrcOff = dnIf.data[BW_CRCOFF];
  assign macPadOff = dnIf.data[BW_PADOFF];
  assign inReady = r_q.rdy;
  assign transmitErrorFlag = r_q.err;
  assign bufferLoadedFlag = r_q.done;
  assign statusValid = r_q.stV;
  assign statusTag = r_q.stTag;
  assign statusLenErr = r_q.stErr;

  // byte toward the buffer; control bits travel with it so a new
  // packet's settings never touch bytes still queued
  assign take = inValid && r_q.rdy;
  assign push = (r_q.st == ST_EMIT);
  assign upIf.valid = push;
  assign upIf.data = {
    r_q.ls && (r_q.left == 11'h001),
    r_q.crcOff && !r_q.padOff,
    r_q.padOff,
    r_q.word[{r_q.idx, 3'h0} +: 8]
  };
  assign sumNext = r_q.sum + r_q.size;

  // parser and counters
  always_comb begin
    logic [11:0] span;
    logic [9:0] dataDw;
    logic [10:0] total;
    logic [2:0] amask;
    logic [10:0] negTot;
    logic errSet;
    logic doneSet;
    span = '0;
    dataDw = '0;
    total = '0;
    amask = MASK_4;
    negTot = '0;
    errSet = 1'b0;
    doneSet = 1'b0;
    r_d = r_q;
    r_d.stV = 1'b0;
    case (r_q.st)
      ST_CMDA: begin
        if (take) begin
          r_d.size = inDword[SIZE_W-1:0];
          r_d.lane = inDword[A_OFF_LO +: 2];
          r_d.skip = inDword[A_OFF_LO+2 +: 3];
          r_d.align = inDword[A_ALIGN_LO +: 2];
          r_d.fs = inDword[A_FS_BIT];
          r_d.ls = inDword[A_LS_BIT];
          r_d.irq = inDword[A_IRQ_BIT];
          r_d.st = ST_CMDB;
        end
      end
      ST_CMDB: begin
        if (take) begin
          // settings held from the opening buffer only
          if (r_q.fs) begin
            r_d.tag = inDword[B_TAG_LO +: TAG_W];
            r_d.crcOff = inDword[B_CRCOFF_BIT];
            r_d.padOff = inDword[B_PADOFF_BIT];
            r_d.len = inDword[SIZE_W-1:0];
            r_d.sum = '0;
          end
          // filler dwords: round data region up to the alignment
          if (r_q.align == ALIGN_16) begin
            amask = MASK_16;
          end else if (r_q.align == ALIGN_32) begin
            amask = MASK_32;
          end
          span = {1'b0, r_q.size} + {10'h000, r_q.lane};
          if (r_q.size != 11'h000) begin
            span = span + 12'h003;
            dataDw = span[11:2];
          end
          total = {1'b0, dataDw} + {8'h00, r_q.skip};
          negTot = 11'h000 - total;
          r_d.pad = negTot[2:0] & amask;
          r_d.dw = dataDw;
          r_d.left = r_q.size;
          r_d.first = 1'b1;
          if (r_q.skip != 3'h0) begin
            r_d.st = ST_SKIP;
          end else if (dataDw != 10'h000) begin
            r_d.st = ST_DATA;
          end else if (r_d.pad != 3'h0) begin
            r_d.st = ST_PAD;
          end else begin
            r_d.st = ST_FIN;
          end
        end
      end
      ST_SKIP: begin
        // whole offset dwords are taken and dropped
        if (take) begin
          r_d.skip = r_q.skip - 3'h1;
          // an empty buffer has no data dword to wait for
          if (r_q.skip == 3'h1) begin
            if (r_q.dw != 10'h000) begin
              r_d.st = ST_DATA;
            end else if (r_q.pad != 3'h0) begin
              r_d.st = ST_PAD;
            end else begin
              r_d.st = ST_FIN;
            end
          end
        end
      end
      ST_DATA: begin
        if (take) begin
          r_d.word = inDword;
          r_d.idx = r_q.first ? r_q.lane : 2'h0;
          r_d.first = 1'b0;
          r_d.st = ST_EMIT;
        end
      end
      ST_EMIT: begin
        // one byte per cycle while the buffer has room
        if (upIf.ready) begin
          r_d.left = r_q.left - 11'h001;
          r_d.idx = r_q.idx + 2'h1;
          if (r_q.left == 11'h001) begin
            r_d.st = (r_q.pad != 3'h0) ? ST_PAD : ST_FIN;
          end else if (r_q.idx == 2'h3) begin
            r_d.st = ST_DATA;
          end
        end
      end
      ST_PAD: begin
        if (take) begin
          r_d.pad = r_q.pad - 3'h1;
          if (r_q.pad == 3'h1) begin
            r_d.st = ST_FIN;
          end
        end
      end
      ST_FIN: begin
        // closing buffer: compare, report, restart the sum
        if (r_q.ls) begin
          errSet = (sumNext != r_q.len);
          r_d.stV = 1'b1;
          r_d.stErr = errSet;
          r_d.stTag = r_q.tag;
          r_d.sum = '0;
        end else begin
          r_d.sum = sumNext;
        end
        doneSet = r_q.irq;
        r_d.st = ST_CMDA;
      end
      default: begin
        r_d.st = ST_CMDA;
      end
    endcase
    // sticky flags: a set in the clearing cycle wins
    r_d.err = errSet || (r_q.err && !errClear);
    r_d.done = doneSet || (r_q.done && !doneClear);
    // ready is registered, so it follows the next state
    r_d.rdy = (r_d.st != ST_EMIT) && (r_d.st != ST_FIN);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // checks
  property p_first_lane;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_DATA) && take && r_q.first |=> r_q.idx == $past(r_q.lane);
  endproperty
  a_first_lane: assert property (p_first_lane)
    else $error("first byte lane differs from offset");

  property p_skip_silent;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_SKIP) && take |=> !push;
  endproperty
  a_skip_silent: assert property (p_skip_silent)
    else $error("skipped dword produced a byte");

  property p_len_err;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_FIN) && r_q.ls && (sumNext != r_q.len)
      |=> transmitErrorFlag && statusLenErr && statusValid;
  endproperty
  a_len_err: assert property (p_len_err)
    else $error("length mismatch not flagged");

  property p_sum_clear;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_FIN) && r_q.ls |=> (r_q.sum == 11'h000) ##1 !statusValid;
  endproperty
  a_sum_clear: assert property (p_sum_clear)
    else $error("sum not cleared after closing buffer");

  property p_crc_kept;
    @(posedge clk) disable iff (sys_rst)
    macValid && macPadOff |-> !macCrcOff;
  endproperty
  a_crc_kept: assert property (p_crc_kept)
    else $error("check sequence dropped with padding off");

  property p_tag_copy;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_FIN) && r_q.ls |=> statusTag == $past(r_q.tag);
  endproperty
  a_tag_copy: assert property (p_tag_copy)
    else $error("status tag differs from packet tag");

  property p_loaded;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_FIN) && r_q.irq |=> bufferLoadedFlag;
  endproperty
  a_loaded: assert property (p_loaded)
    else $error("loaded flag missing");

  property p_no_trail;
    @(posedge clk) disable iff (sys_rst)
    push |-> r_q.left != 11'h000;
  endproperty
  a_no_trail: assert property (p_no_trail)
    else $error("byte pushed past buffer size");

  property p_pad_drop;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_PAD) && take && (r_q.pad == 3'h1) |=> r_q.st == ST_FIN;
  endproperty
  a_pad_drop: assert property (p_pad_drop)
    else $error("filler count wrong");

  property p_hold_b;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_CMDB) && take && !r_q.fs |=> $stable(r_q.tag);
  endproperty
  a_hold_b: assert property (p_hold_b)
    else $error("settings changed on later buffer");

  property p_skip_end;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_SKIP) && take && (r_q.skip == 3'h1) && (r_q.dw == 10'h000)
      |=> r_q.st != ST_DATA;
  endproperty
  a_skip_end: assert property (p_skip_end)
    else $error("empty buffer waits for a data dword");

  property p_mac_hold;
    @(posedge clk) disable iff (sys_rst)
    macValid && !macReady
      |=> macValid && $stable(macByte) && $stable(macLast);
  endproperty
  a_mac_hold: assert property (p_mac_hold)
    else $error("stalled byte changed before it was taken");

  property p_err_sticky;
    @(posedge clk) disable iff (sys_rst)
    transmitErrorFlag && !errClear |=> transmitErrorFlag;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag dropped without a clear");

  property p_sum_acc;
    @(posedge clk) disable iff (sys_rst)
    (r_q.st == ST_FIN) && !r_q.ls |=> r_q.sum == $past(sumNext);
  endproperty
  a_sum_acc: assert property (p_sum_acc)
    else $error("running sum not accumulated");

  property p_status_pulse;
    @(posedge clk) disable iff (sys_rst)
    statusValid |=> !statusValid;
  endproperty
  a_status_pulse: assert property (p_status_pulse)
    else $error("status pulse longer than one cycle");

  c_err: cover property (@(posedge clk) statusValid && statusLenErr);
  c_pad: cover property (@(posedge clk) r_q.st == ST_PAD);
  c_skip: cover property (@(posedge clk) r_q.st == ST_SKIP);
  c_stall: cover property (@(posedge clk) macValid && !macReady);
endmodule

// [pkg/txu_pkg.sv]
/*
  Constants, command word fields and state codes of the transmit
  buffer unpacker. Assumes one system clock and a synchronous reset.
*/
// Overview of operation
// - command A bit13 opens, bit12 closes packet
// - command A bits 10:0 give buffer bytes
// - size, offset and alignment give filler dwords, dropped
// - sum buffer sizes, mismatch raises error flag
// - command B tag copied into status
// - tag carried unchanged, never interpreted
// - command B bit13 suppresses frame check sequence
// - command B bit12 suppresses short frame padding
// - padding disabled still forces check sequence
// - command B bits 10:0 give packet length
// - command A, then B, then data dwords
// - offset low bits pick first byte lane
// - offset bits 4:2 skip whole dwords
// - trailing unused bytes never reach MAC
// - end alignment filler stripped automatically
// - alignment field 00/01/10 means 4/16/32
// - offset field bits 20:16, 0 to 31
// - command A bit31 flags buffer fully loaded
package txu_pkg;
  // command A fields
  localparam int A_IRQ_BIT = 31;
  localparam int A_ALIGN_LO = 24;
  localparam int A_OFF_LO = 16;
  localparam int A_FS_BIT = 13;
  localparam int A_LS_BIT = 12;
  localparam int SIZE_W = 11;
  // command B fields
  localparam int B_TAG_LO = 16;
  localparam int TAG_W = 16;
  localparam int B_CRCOFF_BIT = 13;
  localparam int B_PADOFF_BIT = 12;
  // end alignment codes and their dword masks
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [2:0] MASK_4 = 3'h0;
  localparam logic [2:0] MASK_16 = 3'h3;
  localparam logic [2:0] MASK_32 = 3'h7;
  // buffer word: {last, crcOff, padOff, byte}
  localparam int BUF_W = 11;
  localparam int BW_LAST = 10;
  localparam int BW_CRCOFF = 9;
  localparam int BW_PADOFF = 8;
  typedef enum logic [2:0] {
    ST_CMDA = 3'h0,
    ST_CMDB = 3'h1,
    ST_SKIP = 3'h3,
    ST_DATA = 3'h2,
    ST_EMIT = 3'h6,
    ST_PAD = 3'h7,
    ST_FIN = 3'h5
  } txu_state_type;
endpackage

// [pkg/txu_stream_if.sv]
/*
  Valid/ready stream between the unpacker and its byte buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface txu_stream_if #(parameter int W = 11);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// [hw/txu_skid_buf.sv]
/*
  Two-entry skid buffer, all outputs from flip-flops.
  Assumes a synchronous active-high reset.
*/
`timescale 1ns/10ps
module txu_skid_buf #(
  parameter int W = 11
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  txu_stream_if.snk upI, // filling side
  txu_stream_if.src dnI // draining side
);
  typedef struct packed {
    logic [W-1:0] outD;
    logic outV;
    logic [W-1:0] skD;
    logic skV;
  } txu_skid_type;
  txu_skid_type r_q, r_d;
  // ready only while the skid slot is free, so no word is lost
  assign upI.ready = ~r_q.skV;
  assign dnI.data = r_q.outD;
  assign dnI.valid = r_q.outV;
  // drain first, then fill whichever slot is free
  always_comb begin
    r_d = r_q;
    if (r_q.outV && dnI.ready) begin
      if (r_q.skV) begin
        r_d.outD = r_q.skD;
        r_d.skV = 1'b0;
      end else begin
        r_d.outV = 1'b0;
      end
    end
    if (upI.valid && !r_q.skV) begin
      if (!r_d.outV) begin
        r_d.outD = upI.data;
        r_d.outV = 1'b1;
      end else begin
        r_d.skD = upI.data;
        r_d.skV = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule

// [test/txu_host_model.sv]
/*
  Host model: builds transmit buffers and feeds them to the unpacker
  as dwords. Assumes a dword is taken on an edge with valid and ready.
*/
`timescale 1ns/10ps
module txu_host_model (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  output logic [31:0] inDword, // dword to unpacker
  output logic inValid, // dword present
  input wire logic inReady // dword taken
);
  logic [31:0] q[$];
  initial begin
    inDword = 32'h0;
    inValid = 1'b0;
  end
  // hold each dword until taken; an idle bus shows the inverted value
  always @(posedge clk) begin
    if (sys_rst) begin
      inValid <= 1'b0;
    end else if (!inValid || inReady) begin
      if (q.size() > 0) begin
        inDword <= q.pop_front();
        inValid <= 1'b1;
      end else begin
        inDword <= ~inDword;
        inValid <= 1'b0;
      end
    end
  end
  // one buffer: commands, skipped dwords, payload lanes, end filler
  task automatic send_buf(input logic [31:0] cmdA, input logic [31:0] cmdB,
    input logic [7:0] b0);
    int n, lane, data, tot, mask, idx;
    logic [31:0] w;
    n = int'(cmdA[10:0]);
    lane = int'(cmdA[17:16]);
    mask = (cmdA[25:24] == 2'h1) ? 3 : (cmdA[25:24] == 2'h2) ? 7 : 0;
    data = (n == 0) ? 0 : (lane + n + 3) / 4;
    tot = int'(cmdA[20:18]) + data;
    q.push_back(cmdA);
    q.push_back(cmdB);
    for (int i = 0; i < int'(cmdA[20:18]); i++)
      q.push_back(32'hC0DE0000 | 32'(i));
    for (int d = 0; d < data; d++) begin
      for (int l = 0; l < 4; l++) begin
        idx = d * 4 + l - lane;
        w[l*8 +: 8] = (idx >= 0 && idx < n) ? b0 + 8'(idx) : 8'h5A;
      end
      q.push_back(w);
    end
    for (int i = tot; i < ((tot + mask) & ~mask); i++)
      q.push_back(32'hF111F111);
  endtask
endmodule

// [test/testbench.sv]
/*
  Self-checking bench of the transmit buffer unpacker.
  Assumes the host model above and a 250 MHz system clock.
*/
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] inDword;
  logic inValid, inReady, macValid, macLast, macCrcOff, macPadOff;
  logic macReady = 1'b1;
  logic [7:0] macByte;
  logic transmitErrorFlag, bufferLoadedFlag, statusValid, statusLenErr;
  logic errClear = 1'b0;
  logic doneClear = 1'b0;
  logic [15:0] statusTag;
  logic stallOn = 1'b0;
  logic [10:0] got[$];
  int mismatches = 0;
  int compares = 0;
  int statusCount = 0;

  always #2 clk = ~clk;

  txu_host_model txu_host_model_inst (.clk(clk), .sys_rst(sys_rst),
    .inDword(inDword), .inValid(inValid), .inReady(inReady));
  txu_unpacker txu_unpacker_inst (.clk(clk), .sys_rst(sys_rst),
    .inDword(inDword), .inValid(inValid), .inReady(inReady),
    .macByte(macByte), .macValid(macValid), .macReady(macReady),
    .macLast(macLast), .macCrcOff(macCrcOff), .macPadOff(macPadOff),
    .transmitErrorFlag(transmitErrorFlag), .errClear(errClear),
    .bufferLoadedFlag(bufferLoadedFlag), .doneClear(doneClear),
    .statusValid(statusValid), .statusTag(statusTag),
    .statusLenErr(statusLenErr));

  // mac side takes every byte, or every other cycle while stalling
  always @(posedge clk) begin
    macReady <= stallOn ? ~macReady : 1'b1;
    if (macValid && macReady)
      got.push_back({macLast, macCrcOff, macPadOff, macByte});
    if (statusValid)
      statusCount <= statusCount + 1;
  end

  task automatic check_bit(input string name, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", name, e, s);
    end
  endtask
  task automatic check_vec(input string name, input logic [15:0] e,
    input logic [15:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic send(input logic [31:0] a, input logic [31:0] b,
    input logic [7:0] b0);
    txu_host_model_inst.send_buf(a, b, b0);
  endtask
  // bounded wait, then bytes checked in order with their flags
  task automatic expect_bytes(input int n, input logic [7:0] b0,
    input logic last, input logic crc, input logic pad);
    logic [10:0] e;
    for (int i = 0; i < 400 && got.size() < n; i++)
      @(posedge clk);
    check_vec("byte count", 16'(n),
      (got.size() < n) ? 16'(got.size()) : 16'(n));
    for (int i = 0; i < n && got.size() > 0; i++) begin
      e = {last && i == n - 1, crc, pad, b0 + 8'(i)};
      check_vec("mac word", {5'h00, e}, {5'h00, got.pop_front()});
    end
  endtask
  task automatic end_pkt(input int s, input logic [15:0] tag, input logic err);
    for (int i = 0; i < 400 && statusCount <= s; i++)
      @(posedge clk);
    @(negedge clk);
    check_vec("status count", 16'(s + 1), 16'(statusCount));
    check_vec("status tag", tag, statusTag);
    check_bit("status length error", err, statusLenErr);
    check_bit("error flag", err, transmitErrorFlag);
    check_vec("leftover bytes", 16'h0000, 16'(got.size()));
  endtask

  // one closing buffer of two bytes
  task automatic t_single;
    int s;
    @(negedge clk);
    s = statusCount;
    send(32'h00003002, 32'h12340002, 8'h10);
    expect_bytes(2, 8'h10, 1'b1, 1'b0, 1'b0);
    end_pkt(s, 16'h1234, 1'b0);
  endtask
  // every alignment code, start lanes 3 to 1, dword skips 0, 3 and 6, mac stalling
  task automatic t_align;
    logic [31:0] a;
    int s;
    stallOn = 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      s = statusCount;
      a = {6'h00, 2'(k), 3'h0, 3'(k * 3), 2'(3 - k), 4'h3, 1'b0, 11'(5 + k)};
      send(a, {16'h00A0 + 16'(k), 5'h00, 11'(5 + k)}, 8'h40);
      expect_bytes(5 + k, 8'h40, 1'b1, 1'b0, 1'b0);
      end_pkt(s, 16'h00A0 + 16'(k), 1'b0);
    end
    stallOn = 1'b0;
  endtask
  // three buffers; only the opening command b counts
  task automatic t_multi;
    int s;
    @(negedge clk);
    s = statusCount;
    send(32'h00002003, 32'hBEEF2009, 8'h20);
    send(32'h00010004, 32'h77770001, 8'h30);
    send(32'h00001002, 32'h77771001, 8'h60);
    expect_bytes(3, 8'h20, 1'b0, 1'b1, 1'b0);
    expect_bytes(4, 8'h30, 1'b0, 1'b1, 1'b0);
    expect_bytes(2, 8'h60, 1'b1, 1'b1, 1'b0);
    end_pkt(s, 16'hBEEF, 1'b0);
  endtask
  // length disagrees with size, then the sticky flag is cleared
  task automatic t_mismatch;
    int s;
    @(negedge clk);
    s = statusCount;
    send(32'h00003003, 32'h0F0F0004, 8'h70);
    expect_bytes(3, 8'h70, 1'b1, 1'b0, 1'b0);
    end_pkt(s, 16'h0F0F, 1'b1);
    @(posedge clk);
    errClear <= 1'b1;
    @(posedge clk);
    errClear <= 1'b0;
    @(negedge clk);
    check_bit("error flag cleared", 1'b0, transmitErrorFlag);
  endtask
  // padding off forces the check sequence back on
  task automatic t_padoff;
    int s;
    @(negedge clk);
    s = statusCount;
    send(32'h00023001, 32'h55553001, 8'h80);
    expect_bytes(1, 8'h80, 1'b1, 1'b0, 1'b1);
    end_pkt(s, 16'h5555, 1'b0);
  endtask
  // loaded flag set by bit 31, cleared by the host
  task automatic t_loaded;
    int s;
    @(negedge clk);
    check_bit("loaded flag idle", 1'b0, bufferLoadedFlag);
    s = statusCount;
    send(32'h80003001, 32'h00010001, 8'h90);
    expect_bytes(1, 8'h90, 1'b1, 1'b0, 1'b0);
    end_pkt(s, 16'h0001, 1'b0);
    check_bit("loaded flag", 1'b1, bufferLoadedFlag);
    @(posedge clk);
    doneClear <= 1'b1;
    @(posedge clk);
    doneClear <= 1'b0;
    @(negedge clk);
    check_bit("loaded flag cleared", 1'b0, bufferLoadedFlag);
  endtask

  // empty closing buffer behind two skipped dwords
  task automatic t_empty;
    int s;
    @(negedge clk);
    s = statusCount;
    send(32'h00083000, 32'h0E0E0000, 8'h00);
    end_pkt(s, 16'h0E0E, 1'b0);
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the whole sequence needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_loaded();
    t_single();
    t_align();
    t_multi();
    t_mismatch();
    t_padoff();
    t_empty();
    t_single();
    print_verdict();
  end
endmodule
